// *** shared/smw_pkg.sv ***
// Purpose: constants for the static memory wait-state and reload block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   register offsets are byte addresses
package smw_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned CS_W          = 2;
    localparam logic [7:0]  OFF_CS_SETUP  = 8'h00;
    localparam logic [7:0]  OFF_CS_PULSE  = 8'h04;
    localparam logic [7:0]  OFF_CS_CYCLE  = 8'h08;
    localparam logic [7:0]  OFF_CS_MODE   = 8'h0c;
    localparam logic [7:0]  CS_STRIDE     = 8'h10;
    localparam logic [7:0]  OFF_SCRAMBLE_KEY_PART1      = 8'h84;
    localparam logic [7:0]  OFF_SCRAMBLE_KEY_PART2      = 8'h88;
    localparam logic [7:0]  OFF_CTRL      = 8'h90;
    localparam logic [7:0]  OFF_STATUS    = 8'h94;
    localparam logic [31:0] KEY_RESET     = 32'h0000_0000;
    localparam int unsigned CTRL_SCR_BIT  = 0;
    localparam int unsigned CTRL_SLOW_BIT = 1;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    typedef enum logic [2:0] {
        SMW_IDLE, SMW_CSWAIT, SMW_RELOAD, SMW_TURN, SMW_ACCESS
    } smw_state_type;
endpackage

// *** core/smw_core.sv ***
// Purpose: wait-state insertion, configuration reload and scrambling keys
// Assumes: one clock, synchronous active-low reset, 4 chip selects
// Notes:   external access is modelled by a request/done handshake
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - after a mode register write one reload wait state precedes the next access to the same chip select.
// - a reload wait state is never added on top of a chip-select wait state.
// - a change of chip select across a reconfiguration gives one chip-select wait state only.
// - the same chip select across a mode write gives a reload wait state, whatever chip select was written.
// - only mode register writes and changes of the slow bit mark a reload pending; timing register writes do not.
// - entering or leaving slow clock mode gives a reload wait state before the next access to the same chip select.
// - one wait cycle always sits between a read and a following write.
// - key part two takes only the first write after reset and resets to zero.
// - with scrambling on, data is scrambled by key parts one and two together.
module smw_core
    import smw_pkg::*;
#(
    parameter int unsigned NUM_CS = 4
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // external access request
    input  wire logic              acc_req,
    input  wire logic [CS_W-1:0]   acc_cs,
    input  wire logic              acc_write,
    input  wire logic [31:0]       acc_wdata,
    output logic                   acc_ack,
    output logic                   mem_start,
    output logic [CS_W-1:0]        mem_cs,
    output logic                   mem_write,
    output logic [31:0]            mem_wdata,
    input  wire logic              mem_done,
    // timing set in force and status
    output logic [31:0]            act_setup,
    output logic [31:0]            act_pulse,
    output logic [31:0]            act_cycle,
    output logic [31:0]            act_mode,
    output logic                   reload_wait
);
    // address decode and the parameter copy are built for four chip selects only
    if (NUM_CS != 4) begin : g_bad_cs
        $error("smw_core supports exactly 4 chip selects");
    end

    logic [31:0] cfg_reg [4*NUM_CS];
    logic [31:0] cfg_next [4*NUM_CS];
    logic [31:0] scramble_key_part1_reg, scramble_key_part1_next, scramble_key_part2_reg, scramble_key_part2_next;
    logic        scramble_key_part2_lock_reg, scramble_key_part2_lock_next;
    logic        scr_en_reg, scr_en_next, slow_reg, slow_next;
    logic        pend_reg, pend_next;
    logic        aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
    logic [ADDR_W-1:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    smw_state_type st_reg, st_next;
    logic [CS_W-1:0] last_cs_reg, last_cs_next, cur_cs_reg, cur_cs_next;
    logic        last_rd_reg, last_rd_next, any_acc_reg, any_acc_next;
    logic        cur_wr_reg, cur_wr_next;
    logic [31:0] cur_wd_reg, cur_wd_next;
    logic [31:0] act_reg [4];
    logic [31:0] act_next [4];
    logic        do_wr, mode_wr;

    function automatic logic [31:0] scramble(input logic [31:0] d, input logic [CS_W-1:0] cs);
        scramble = d ^ scramble_key_part1_reg ^ {scramble_key_part2_reg[15:0], scramble_key_part2_reg[31:16]} ^ {30'h0, cs};
    endfunction

    function automatic logic is_mode(input logic [ADDR_W-1:0] a);
        is_mode = (a < 8'h40) && (a[3:0] == OFF_CS_MODE[3:0]);
    endfunction

    assign s_axi_awready = !aw_reg && !b_reg;
    assign s_axi_wready  = !w_reg && !b_reg;
    assign s_axi_bvalid  = b_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = !r_reg;
    assign s_axi_rvalid  = r_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;
    assign do_wr   = aw_reg && w_reg && !b_reg;
    assign mode_wr = do_wr && is_mode(awa_reg);

    always_comb begin
        aw_next = aw_reg; w_next = w_reg; b_next = b_reg; r_next = r_reg;
        awa_next = awa_reg; wd_next = wd_reg; br_next = br_reg;
        rd_next = rd_reg; rr_next = rr_reg;
        scramble_key_part1_next = scramble_key_part1_reg; scramble_key_part2_next = scramble_key_part2_reg; scramble_key_part2_lock_next = scramble_key_part2_lock_reg;
        scr_en_next = scr_en_reg; slow_next = slow_reg;
        for (int i = 0; i < 4*NUM_CS; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
        end
        if (do_wr) begin
            aw_next = 1'b0; w_next = 1'b0; b_next = 1'b1; br_next = RESP_OKAY;
            if (awa_reg < 8'h40 && awa_reg[1:0] == 2'b00) begin
                cfg_next[awa_reg[5:2]] = wd_reg;
            end else if (awa_reg == OFF_SCRAMBLE_KEY_PART1) begin
                scramble_key_part1_next = wd_reg;
            end else if (awa_reg == OFF_SCRAMBLE_KEY_PART2) begin
                if (!scramble_key_part2_lock_reg) begin
                    scramble_key_part2_next = wd_reg;
                    scramble_key_part2_lock_next = 1'b1;
                end
            end else if (awa_reg == OFF_CTRL) begin
                scr_en_next = wd_reg[CTRL_SCR_BIT];
                slow_next = wd_reg[CTRL_SLOW_BIT];
            end else begin
                br_next = RESP_SLVERR;
            end
        end
        if (b_reg && s_axi_bready) b_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            r_next = 1'b1; rr_next = RESP_OKAY; rd_next = 32'h0000_0000;
            if (s_axi_araddr < 8'h40 && s_axi_araddr[1:0] == 2'b00) begin
                rd_next = cfg_reg[s_axi_araddr[5:2]];
            end else if (s_axi_araddr == OFF_CTRL) begin
                rd_next = {30'h0, slow_reg, scr_en_reg};
            end else if (s_axi_araddr == OFF_STATUS) begin
                rd_next = {28'h0, scramble_key_part2_lock_reg, (st_reg == SMW_RELOAD), pend_reg, (st_reg != SMW_IDLE)};
            end else if (s_axi_araddr != OFF_SCRAMBLE_KEY_PART1 && s_axi_araddr != OFF_SCRAMBLE_KEY_PART2) begin
                rr_next = RESP_SLVERR;  // keys are write-only and read zero
            end
        end
        if (r_reg && s_axi_rready) r_next = 1'b0;
    end

    // access sequencer
    always_comb begin
        st_next = st_reg; pend_next = pend_reg;
        last_cs_next = last_cs_reg; last_rd_next = last_rd_reg; any_acc_next = any_acc_reg;
        cur_cs_next = cur_cs_reg; cur_wr_next = cur_wr_reg; cur_wd_next = cur_wd_reg;
        for (int i = 0; i < 4; i++) begin
            act_next[i] = act_reg[i];
        end
        acc_ack = 1'b0; mem_start = 1'b0;
        if (mode_wr) pend_next = 1'b1;
        if (slow_next != slow_reg) pend_next = 1'b1;
        case (st_reg)
            SMW_IDLE: begin
                if (acc_req) begin
                    acc_ack = 1'b1;
                    cur_cs_next = acc_cs;
                    cur_wr_next = acc_write;
                    // scrambled at acceptance so the data output comes straight from a flop
                    cur_wd_next = scr_en_reg ? scramble(acc_wdata, acc_cs) : acc_wdata;
                    if (any_acc_reg && acc_cs != last_cs_reg) begin
                        st_next = SMW_CSWAIT;
                    end else if (pend_reg || mode_wr) begin
                        st_next = SMW_RELOAD;
                    end else if (last_rd_reg && acc_write) begin
                        st_next = SMW_TURN;
                    end else begin
                        st_next = SMW_ACCESS;
                    end
                end
            end
            SMW_CSWAIT, SMW_RELOAD, SMW_TURN: begin
                // cs wait also absorbs a pending reload and the turnaround
                for (int i = 0; i < 4; i++) begin
                    act_next[i] = cfg_reg[{cur_cs_reg, 2'(i)}];
                end
                pend_next = mode_wr || (slow_next != slow_reg);
                st_next = SMW_ACCESS;
            end
            SMW_ACCESS: begin
                mem_start = 1'b1;
                if (mem_done) begin
                    st_next = SMW_IDLE;
                    last_cs_next = cur_cs_reg; last_rd_next = !cur_wr_reg; any_acc_next = 1'b1;
                end
            end
            default: st_next = SMW_IDLE;
        endcase
    end

    assign mem_cs      = cur_cs_reg;
    assign mem_write   = cur_wr_reg;
    assign mem_wdata   = cur_wd_reg;
    assign act_setup   = act_reg[0];
    assign act_pulse   = act_reg[1];
    assign act_cycle   = act_reg[2];
    assign act_mode    = act_reg[3];
    assign reload_wait = (st_reg == SMW_RELOAD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; r_reg <= 1'b0;
            awa_reg <= '0; wd_reg <= '0; br_reg <= RESP_OKAY; rd_reg <= '0; rr_reg <= RESP_OKAY;
            scramble_key_part1_reg <= KEY_RESET; scramble_key_part2_reg <= KEY_RESET; scramble_key_part2_lock_reg <= 1'b0;
            scr_en_reg <= 1'b0; slow_reg <= 1'b0; pend_reg <= 1'b0;
            st_reg <= SMW_IDLE; last_cs_reg <= '0; last_rd_reg <= 1'b0; any_acc_reg <= 1'b0;
            cur_cs_reg <= '0; cur_wr_reg <= 1'b0; cur_wd_reg <= '0;
            for (int i = 0; i < 4*NUM_CS; i++) cfg_reg[i] <= '0;
            for (int i = 0; i < 4; i++) act_reg[i] <= '0;
        end else begin
            aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next; r_reg <= r_next;
            awa_reg <= awa_next; wd_reg <= wd_next; br_reg <= br_next;
            rd_reg <= rd_next; rr_reg <= rr_next;
            scramble_key_part1_reg <= scramble_key_part1_next; scramble_key_part2_reg <= scramble_key_part2_next; scramble_key_part2_lock_reg <= scramble_key_part2_lock_next;
            scr_en_reg <= scr_en_next; slow_reg <= slow_next; pend_reg <= pend_next;
            st_reg <= st_next; last_cs_reg <= last_cs_next; last_rd_reg <= last_rd_next;
            any_acc_reg <= any_acc_next;
            cur_cs_reg <= cur_cs_next; cur_wr_reg <= cur_wr_next; cur_wd_reg <= cur_wd_next;
            for (int i = 0; i < 4*NUM_CS; i++) cfg_reg[i] <= cfg_next[i];
            for (int i = 0; i < 4; i++) act_reg[i] <= act_next[i];
        end
    end
endmodule
`default_nettype wire

// *** verification/smw_chk.sv ***
// Purpose: port assertions on wait-state insertion
// Assumes: one clock, sync active-low reset
// Notes:   helper regs remember the last finished access
`timescale 1ns/1ps
`default_nettype none
module smw_chk
    import smw_pkg::*;
(
    // clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // access side
    input wire logic            acc_ack,
    input wire logic            acc_write,
    input wire logic            mem_start,
    input wire logic            mem_done,
    input wire logic            mem_write,
    input wire logic            reload_wait,
    input wire logic [CS_W-1:0] acc_cs,
    input wire logic [CS_W-1:0] mem_cs
);
    logic            seen_reg, seen_next, rd_reg, rd_next;
    logic [CS_W-1:0] cs_reg, cs_next;
    always_comb begin
        seen_next = seen_reg | (mem_start & mem_done);
        rd_next   = (mem_start & mem_done) ? !mem_write : rd_reg;
        cs_next   = (mem_start & mem_done) ? mem_cs : cs_reg;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) {seen_reg, rd_reg, cs_reg} <= '0;
        else {seen_reg, rd_reg, cs_reg} <= {seen_next, rd_next, cs_next};
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reload_one_cycle: assert property (reload_wait |=> !reload_wait)
        else $error("reload wait longer than one cycle");
    a_reload_then_start: assert property (reload_wait |=> mem_start)
        else $error("access did not follow reload wait");
    a_reload_after_ack: assert property (reload_wait |-> $past(acc_ack))
        else $error("reload wait without a taken request");
    a_single_wait: assert property (acc_ack |-> ##[1:2] mem_start)
        else $error("wait states accumulated");
    a_cs_wait_only: assert property (acc_ack && seen_reg && acc_cs != cs_reg |=> !mem_start && !reload_wait)
        else $error("chip select change wait wrong");
    a_turn_wait: assert property (acc_ack && acc_write && rd_reg |=> !mem_start)
        else $error("no turnaround after read");
    a_first_no_wait: assert property (acc_ack && !seen_reg |=> mem_start)
        else $error("wait before first access");
    a_start_hold: assert property (mem_start && !mem_done |=> mem_start)
        else $error("access dropped before done");
    c_reload: cover property (reload_wait);
    c_turn: cover property (acc_ack && acc_write && rd_reg);
    c_cs: cover property (acc_ack && seen_reg && acc_cs != cs_reg);
endmodule
bind smw_core smw_chk i_smw_chk(.aclk, .aresetn, .acc_ack, .acc_write, .mem_start, .mem_done, .mem_write,
    .reload_wait, .acc_cs, .mem_cs);
`default_nettype wire

// *** verification/smw_mem_model.sv ***
// Purpose: external memory answering each access lat+1 cycles after mem_start rises
// Assumes: mem_start stays high until mem_done
// Notes:   lat 0 answers promptly, larger values stall
`timescale 1ns/1ps
`default_nettype none
module smw_mem_model (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // access handshake
    input wire logic       mem_start,
    input wire logic [3:0] lat,
    output logic           mem_done
);
    logic [3:0] cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !mem_start || mem_done) begin
            cnt_reg  <= 4'h0;
            mem_done <= 1'b0;
        end else begin
            cnt_reg  <= cnt_reg + 4'h1;
            mem_done <= (cnt_reg == lat);
        end
    end
endmodule
`default_nettype wire

// *** verification/smw_core_test.sv ***
// Purpose: self-checking bench for the wait-state and key block
// Assumes: AXI4-Lite master tasks, memory model as far side
// Notes:   config writes only between accesses
`timescale 1ns/1ps
`default_nettype none
module smw_core_test;
    import smw_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, acc_req = 0, acc_write = 0, rl;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_ack, mem_start;
    logic mem_write, mem_done, reload_wait;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, acc_wdata = '0, s_axi_rdata, mem_wdata, act_setup, act_pulse, act_cycle;
    logic [31:0] act_mode, nw, last_wd, d;
    logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
    logic [CS_W-1:0] acc_cs = '0, mem_cs;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fail_count = 0, n_checks = 0, cyc = 0;
    smw_core i_smw_core(
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .acc_req       (acc_req),
        .acc_cs        (acc_cs),
        .acc_write     (acc_write),
        .acc_wdata     (acc_wdata),
        .acc_ack       (acc_ack),
        .mem_start     (mem_start),
        .mem_cs        (mem_cs),
        .mem_write     (mem_write),
        .mem_wdata     (mem_wdata),
        .mem_done      (mem_done),
        .act_setup     (act_setup),
        .act_pulse     (act_pulse),
        .act_cycle     (act_cycle),
        .act_mode      (act_mode),
        .reload_wait   (reload_wait)
    );
    smw_mem_model i_smw_mem_model(
        .aclk      (aclk),
        .aresetn   (aresetn),
        .mem_start (mem_start),
        .lat       (lat),
        .mem_done  (mem_done)
    );
    initial forever #25 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] dat);
        logic aw, w, b;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, dat, 3'h7};
        do begin
            @(negedge aclk);
            {aw, w, b, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        // one edge apart so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a);
        logic ar, v;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ar, v, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // one access; counts cycles from acceptance to the access phase
    task automatic ck_acc(input logic [1:0] cs, input logic wr, input logic [31:0] dat, input logic ew, er);
        logic a, mw;
        logic [1:0] mc;
        {acc_req, acc_cs, acc_write, acc_wdata} <= {1'b1, cs, wr, dat};
        do begin
            @(negedge aclk);
            a = acc_ack;
            @(posedge aclk);
        end while (!a);
        acc_req <= 1'b0;
        {nw, rl} = '0;
        @(negedge aclk);
        while (!mem_start) begin
            rl |= reload_wait;
            nw = nw + 32'h1;
            @(negedge aclk);
        end
        last_wd = mem_wdata;
        mc = mem_cs;
        mw = mem_write;
        while (!mem_done) @(negedge aclk);
        @(posedge aclk);
        chk("wait cycles", {31'h0, ew}, nw);
        chk("reload seen", {31'h0, er}, {31'h0, rl});
        chk("mem cs", {30'h0, cs}, {30'h0, mc});
        chk("mem write", {31'h0, wr}, {31'h0, mw});
    endtask
    task automatic t_reload;
        ck_acc(2'h0, 1'b0, 32'h0, 1'b0, 1'b0);
        axw(OFF_CS_MODE + CS_STRIDE, 32'h1);
        ck_acc(2'h0, 1'b0, 32'h0, 1'b1, 1'b1);
        ck_acc(2'h0, 1'b0, 32'h0, 1'b0, 1'b0);
    endtask
    task automatic t_timing;
        axw(OFF_CS_SETUP, 32'h5);
        axw(OFF_CS_PULSE, 32'h6);
        axw(OFF_CS_CYCLE, 32'h9);
        ck_acc(2'h0, 1'b0, 32'h0, 1'b0, 1'b0);
        axw(OFF_CS_MODE, 32'h3);
        ck_acc(2'h0, 1'b0, 32'h0, 1'b1, 1'b1);
        chk("setup in force", 32'h5, act_setup);
        chk("pulse in force", 32'h6, act_pulse);
        chk("cycle in force", 32'h9, act_cycle);
        axr(OFF_CS_SETUP);
        chk("setup readback", 32'h5, d);
        chk("mode in force", 32'h3, act_mode);
    endtask
    task automatic t_cs_turn;
        axw(OFF_CS_MODE, 32'h7);
        ck_acc(2'h1, 1'b0, 32'h0, 1'b1, 1'b0);
        chk("mode cs1", 32'h1, act_mode);
        lat <= 4'h3;
        ck_acc(2'h1, 1'b0, 32'h0, 1'b0, 1'b0);
        ck_acc(2'h1, 1'b1, 32'h0, 1'b1, 1'b0);
        axw(OFF_CTRL, 32'h2);
        ck_acc(2'h1, 1'b1, 32'h0, 1'b1, 1'b1);
    endtask
    task automatic t_key;
        axr(OFF_STATUS);
        chk("key lock at reset", 32'h0, {31'h0, d[3]});
        axw(OFF_SCRAMBLE_KEY_PART2, 32'h1234_abcd);
        chk("scramble_key_part2 resp", {30'h0, RESP_OKAY}, {30'h0, r});
        axw(OFF_SCRAMBLE_KEY_PART2, 32'hffff_0000);
        axw(OFF_SCRAMBLE_KEY_PART1, 32'h0f0f_0f0f);
        axw(OFF_CTRL, 32'h1);
        ck_acc(2'h2, 1'b1, 32'h5555_aaaa, 1'b1, 1'b0);
        chk("scrambled data", 32'h5555_aaaa ^ 32'h0f0f_0f0f ^ 32'habcd_1234 ^ 32'h2, last_wd);
        axr(OFF_STATUS);
        chk("key lock", 32'h1, {31'h0, d[3]});
        axr(OFF_SCRAMBLE_KEY_PART2);
        chk("scramble_key_part2 reads zero", 32'h0, d);
        chk("scramble_key_part2 read resp", {30'h0, RESP_OKAY}, {30'h0, r});
        axr(8'h98);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reload();
        t_timing();
        t_cs_turn();
        t_key();
        test_done();
    end
endmodule
`default_nettype wire
